// *** hdl/sdp_pkg.sv ***
// How it works
// - Deep sleep entry: burst terminate pins with gate falling, all banks idle.
// - Deep sleep powers off the array; every stored word becomes undefined.
// - Deep sleep ends when the gate rises; clock already stable.
// - Mode register survives deep sleep; the wipe leaves it untouched.
// - Gate registered low during a burst starts clock suspend, freezing logic.
// - Each edge sampling the gate low suppresses the following internal edge.
// - Suspended edge ignores commands and data, holds output, freezes burst counters.
// - Gate registered high at edge n ends suspend; commands resume at n+1.
// - Write burst mode bit set makes every write one column; reads unchanged.
// - Read to another bank ends auto-precharging read; precharge starts at once.
// - Write to another bank cuts auto-precharging read immediately; precharge starts, except when that write is one column with auto precharge.
// - Read cuts auto-precharging write; precharge after write recovery from that read.
// - Write cuts auto-precharging write; precharge after write recovery from it.
// - Burst terminate pins mean terminate with gate high, deep sleep when low.
// - Power-down exit at edge n resumes commands at edge n+1; active banks stay active.
package sdp_pkg;
  localparam logic [3:0]  CMD_LMR       = 4'h0;
  localparam logic [3:0]  CMD_REF       = 4'h1;
  localparam logic [3:0]  CMD_PRE       = 4'h2;
  localparam logic [3:0]  CMD_ACT       = 4'h3;
  localparam logic [3:0]  CMD_WR        = 4'h4;
  localparam logic [3:0]  CMD_RD        = 4'h5;
  localparam logic [3:0]  CMD_BST       = 4'h6;
  localparam logic [3:0]  CMD_NOP       = 4'h7;
  localparam int          ADDR_W        = 13;
  localparam int          MR_BL_LSB     = 0;
  localparam int          MR_CL_LSB     = 4;
  localparam int          MR_WB_BIT     = 9;
  localparam int          AP_BIT        = 10;
  localparam logic [12:0] MR_RESET      = 13'h0020;
  localparam logic [2:0]  BL_FULL       = 3'h7;
  localparam int          PIPE_N        = 3;
  localparam int          CLK_PERIOD_PS = 4000;
  localparam int          T_RP_NS       = 20;
  localparam int          T_WR_NS       = 15;
  localparam int          T_XSR_NS      = 120;
  localparam int          DS_WAIT_US    = 100;
  localparam int          RP_CYC        = (T_RP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          WR_CYC        = (T_WR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          XSR_CYC       = (T_XSR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          DS_WAIT_CYC   = (DS_WAIT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          TIM_W         = 16;

  typedef enum logic [2:0] {
    PW_RUN   = 3'h0,
    PW_SUSP  = 3'h1,
    PW_PD    = 3'h3,
    PW_SR    = 3'h2,
    PW_XSR   = 3'h6,
    PW_DS    = 3'h7,
    PW_DSREC = 3'h5
  } sdp_pwr_t;

  typedef enum logic [2:0] {
    BK_IDLE = 3'h0,
    BK_ACT  = 3'h1,
    BK_RDAP = 3'h3,
    BK_WRAP = 3'h2,
    BK_WREC = 3'h6,
    BK_PRE  = 3'h4
  } sdp_bank_t;
endpackage : sdp_pkg

// *** hdl/sdp_fifo.sv ***
`timescale 1ns/10ps
module sdp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_reg, wp_next, rp_reg, rp_next;
  logic [AW:0]      cnt_reg, cnt_next;
  logic             push, pop;

  assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem[rp_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    wp_next  = push ? ((wp_reg == AW'(DEPTH - 1)) ? '0 : wp_reg + 1'b1) : wp_reg;
    rp_next  = pop ? ((rp_reg == AW'(DEPTH - 1)) ? '0 : rp_reg + 1'b1) : rp_reg;
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wp_reg  <= wp_next;
      rp_reg  <= rp_next;
      cnt_reg <= cnt_next;
    end
  end

  // Storage needs no reset; entries are only read once counted in.
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wp_reg] <= in_data;
    end
  end
endmodule : sdp_fifo

// *** hdl/sdp_core.sv ***
`timescale 1ns/10ps
module sdp_core
  import sdp_pkg::*;
#(
  parameter int                DATA_W     = 16,
  parameter int                COL_BITS   = 8,
  parameter int                FIFO_DEPTH = 8,
  parameter int                DS_WAIT    = sdp_pkg::DS_WAIT_CYC,
  parameter logic [DATA_W-1:0] POISON     = '1
) (
  // Clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       rst,
  // Command pins
  input  wire logic                       cke,
  input  wire logic                       cs_n,
  input  wire logic                       ras_n,
  input  wire logic                       cas_n,
  input  wire logic                       we_n,
  input  wire logic [1:0]                 ba,
  input  wire logic [sdp_pkg::ADDR_W-1:0] addr,
  // Data pins
  input  wire logic                       dqm,
  input  wire logic [DATA_W-1:0]          dq_in,
  output logic [DATA_W-1:0]               dq_out,
  output logic                            dq_oe,
  // Status
  output logic                            in_deep_sleep,
  output logic                            in_self_refresh,
  output logic                            in_power_down,
  output logic                            in_suspend,
  output logic                            ds_recovering,
  output logic                            all_idle,
  output logic                            wbuf_ready,
  output logic [sdp_pkg::ADDR_W-1:0]      mode_out
);
  import sdp_pkg::*;
  localparam int WORDS = 4 << COL_BITS;
  localparam int AW    = COL_BITS + 2;
  localparam int FW    = AW + DATA_W;

  logic [DATA_W-1:0] mem [WORDS];
  logic [WORDS-1:0]  valid_reg;

  logic              cke_q_reg, cke_q_next;
  sdp_pwr_t          pwr_reg, pwr_next;
  logic [TIM_W-1:0]  pw_cnt_reg, pw_cnt_next;
  logic [ADDR_W-1:0] mode_reg, mode_next;
  sdp_bank_t         bank_reg [4];
  sdp_bank_t         bank_next [4];
  logic [TIM_W-1:0]  btim_reg [4];
  logic [TIM_W-1:0]  btim_next [4];
  logic              bst_act_reg, bst_act_next;
  logic              bst_rd_reg, bst_rd_next;
  logic              bst_ap_reg, bst_ap_next;
  logic [1:0]        bst_bank_reg, bst_bank_next;
  logic [COL_BITS-1:0] bst_col_reg, bst_col_next;
  logic [COL_BITS:0]   bst_len_reg, bst_len_next;
  logic [COL_BITS:0]   bst_left_reg, bst_left_next;
  logic [PIPE_N-1:0] pv_reg, pv_next, pm_reg, pm_next;
  logic [DATA_W-1:0] pd_reg [PIPE_N];
  logic [DATA_W-1:0] pd_next [PIPE_N];

  logic [3:0]        cmd;
  logic              act, sel, wipe;
  logic              rd_push, wr_push, fin_en, fin_rd;
  logic [1:0]        fin_bank;
  logic [AW-1:0]     rd_addr, wr_addr;
  logic [COL_BITS:0] bl;
  logic [1:0]        lat;
  logic              f_valid, f_ready;
  logic [FW-1:0]     f_data;

  // Burst length code to word count; the full-page code wraps the whole row.
  function automatic logic [COL_BITS:0] burst_words(input logic [2:0] code);
    if (code == BL_FULL) begin
      return (COL_BITS+1)'(WORDS >> 2);
    end
    return (COL_BITS+1)'(1) << code;
  endfunction : burst_words

  // Next column inside the aligned burst block, sequential order.
  function automatic logic [COL_BITS-1:0] next_col(input logic [COL_BITS-1:0] c,
                                                    input logic [COL_BITS:0]   n);
    logic [COL_BITS-1:0] m;
    m = COL_BITS'(n - 1'b1);
    return (c & ~m) | ((c + 1'b1) & m);
  endfunction : next_col

  assign cmd  = {cs_n, ras_n, cas_n, we_n};
  assign sel  = ~cs_n;
  assign bl   = burst_words(mode_reg[MR_BL_LSB +: 3]);
  assign lat  = (mode_reg[MR_CL_LSB +: 2] == 2'h3) ? 2'h2 : 2'h1;
  // Internal edge runs only if the gate was high at the previous edge.
  assign act  = cke_q_reg && (pwr_reg == PW_RUN || pwr_reg == PW_DSREC);
  assign wbuf_ready = f_ready;

  always_comb begin
    all_idle = 1'b1;
    for (int b = 0; b < 4; b++) begin
      if (bank_reg[b] != BK_IDLE) begin
        all_idle = 1'b0;
      end
    end
  end

  // Power state group.
  always_comb begin
    cke_q_next  = cke;
    pwr_next    = pwr_reg;
    pw_cnt_next = pw_cnt_reg;
    wipe        = 1'b0;
    case (pwr_reg)
      PW_RUN, PW_DSREC: begin
        if (pwr_reg == PW_DSREC) begin
          pw_cnt_next = pw_cnt_reg - 1'b1;
          if (pw_cnt_reg <= TIM_W'(1)) begin
            pwr_next = PW_RUN;
          end
        end
        if (cke_q_reg && !cke) begin
          if (bst_act_reg) begin
            pwr_next = PW_SUSP;
          end else if (all_idle && sel && cmd == CMD_BST) begin
            pwr_next = PW_DS;
            wipe     = 1'b1;
          end else if (all_idle && sel && cmd == CMD_REF) begin
            pwr_next = PW_SR;
          end else if (!sel || cmd == CMD_NOP) begin
            pwr_next = PW_PD;
          end
        end
      end
      PW_SUSP, PW_PD: begin
        if (cke) begin
          pwr_next = PW_RUN;
        end
      end
      PW_SR: begin
        if (cke) begin
          pwr_next    = PW_XSR;
          pw_cnt_next = TIM_W'(XSR_CYC);
        end
      end
      PW_XSR: begin
        pw_cnt_next = pw_cnt_reg - 1'b1;
        if (pw_cnt_reg <= TIM_W'(1)) begin
          pwr_next = PW_RUN;
        end
      end
      PW_DS: begin
        if (cke) begin
          pwr_next    = PW_DSREC;
          pw_cnt_next = TIM_W'(DS_WAIT);
        end
      end
      default: pwr_next = PW_RUN;
    endcase
  end

  // Command, bank and burst group.
  always_comb begin
    mode_next     = mode_reg;
    bst_act_next  = bst_act_reg;
    bst_rd_next   = bst_rd_reg;
    bst_ap_next   = bst_ap_reg;
    bst_bank_next = bst_bank_reg;
    bst_col_next  = bst_col_reg;
    bst_len_next  = bst_len_reg;
    bst_left_next = bst_left_reg;
    pv_next       = pv_reg;
    pm_next       = pm_reg;
    pd_next       = pd_reg;
    rd_push       = 1'b0;
    wr_push       = 1'b0;
    rd_addr       = {bst_bank_reg, bst_col_reg};
    wr_addr       = {bst_bank_reg, bst_col_reg};
    fin_en        = 1'b0;
    fin_rd        = bst_rd_reg;
    fin_bank      = bst_bank_reg;
    for (int b = 0; b < 4; b++) begin
      bank_next[b] = bank_reg[b];
      btim_next[b] = btim_reg[b];
      if (bank_reg[b] == BK_PRE || bank_reg[b] == BK_WREC) begin
        btim_next[b] = btim_reg[b] - 1'b1;
        if (btim_reg[b] <= TIM_W'(1)) begin
          bank_next[b] = (bank_reg[b] == BK_PRE) ? BK_IDLE : BK_PRE;
          btim_next[b] = (bank_reg[b] == BK_PRE) ? '0 : TIM_W'(RP_CYC);
        end
      end
    end
    // A frozen edge leaves the pipe, burst counters and command decode untouched.
    if (act) begin
      pv_next = {1'b0, pv_reg[PIPE_N-1:1]};
      pm_next = {1'b0, pm_reg[PIPE_N-1:1]};
      for (int i = 0; i < PIPE_N - 1; i++) begin
        pd_next[i] = pd_reg[i+1];
      end
      pm_next[1] = dqm;
      if (sel && (cmd == CMD_RD || cmd == CMD_WR)) begin
        if (bst_act_reg && bst_ap_reg && ba != bst_bank_reg) begin
          fin_en = 1'b1;
        end
        if (cmd == CMD_WR && bst_act_reg && bst_rd_reg) begin
          pv_next = '0;
        end
        bst_rd_next   = (cmd == CMD_RD);
        bst_ap_next   = addr[AP_BIT];
        bst_bank_next = ba;
        bst_len_next  = (cmd == CMD_WR && mode_reg[MR_WB_BIT]) ? (COL_BITS+1)'(1) : bl;
        bst_left_next = bst_len_next - 1'b1;
        bst_col_next  = next_col(addr[COL_BITS-1:0], bst_len_next);
        bst_act_next  = (bst_left_next != '0);
        rd_push       = (cmd == CMD_RD);
        wr_push       = (cmd == CMD_WR) && !dqm;
        rd_addr       = {ba, addr[COL_BITS-1:0]};
        wr_addr       = {ba, addr[COL_BITS-1:0]};
        bank_next[ba] = addr[AP_BIT] ? ((cmd == CMD_RD) ? BK_RDAP : BK_WRAP) : BK_ACT;
        if (!bst_act_next && addr[AP_BIT]) begin
          fin_en   = 1'b1;
          fin_rd   = (cmd == CMD_RD);
          fin_bank = ba;
        end
      end else if (bst_act_reg && sel && (cmd == CMD_BST ||
                   (cmd == CMD_PRE && (addr[AP_BIT] || ba == bst_bank_reg)))) begin
        bst_act_next = 1'b0;
      end else if (bst_act_reg) begin
        rd_push       = bst_rd_reg;
        wr_push       = !bst_rd_reg && !dqm;
        bst_col_next  = next_col(bst_col_reg, bst_len_reg);
        bst_left_next = bst_left_reg - 1'b1;
        bst_act_next  = (bst_left_next != '0);
        fin_en        = !bst_act_next && bst_ap_reg;
      end
      if (sel && cmd == CMD_ACT) begin
        bank_next[ba] = BK_ACT;
      end
      if (sel && cmd == CMD_PRE) begin
        for (int b = 0; b < 4; b++) begin
          if ((addr[AP_BIT] || ba == 2'(b)) && bank_reg[b] != BK_IDLE) begin
            bank_next[b] = BK_PRE;
            btim_next[b] = TIM_W'(RP_CYC);
          end
        end
      end
      if (sel && cmd == CMD_LMR) begin
        mode_next = addr;
      end
      if (rd_push) begin
        pv_next[lat] = 1'b1;
        pd_next[lat] = valid_reg[rd_addr] ? mem[rd_addr] : POISON;
        if (lat == 2'h1) begin
          pm_next[1] = dqm;
        end
      end
    end
    // Read-side precharge starts now; write side waits out write recovery first.
    if (fin_en) begin
      bank_next[fin_bank] = fin_rd ? BK_PRE : BK_WREC;
      btim_next[fin_bank] = fin_rd ? TIM_W'(RP_CYC) : TIM_W'(WR_CYC);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cke_q_reg    <= 1'b0;
      pwr_reg      <= PW_RUN;
      pw_cnt_reg   <= '0;
      mode_reg     <= MR_RESET;
      bst_act_reg  <= 1'b0;
      bst_rd_reg   <= 1'b0;
      bst_ap_reg   <= 1'b0;
      bst_bank_reg <= '0;
      bst_col_reg  <= '0;
      bst_len_reg  <= '0;
      bst_left_reg <= '0;
      pv_reg       <= '0;
      pm_reg       <= '0;
      for (int i = 0; i < PIPE_N; i++) begin
        pd_reg[i] <= '0;
      end
      for (int b = 0; b < 4; b++) begin
        bank_reg[b] <= BK_IDLE;
        btim_reg[b] <= '0;
      end
    end else begin
      cke_q_reg    <= cke_q_next;
      pwr_reg      <= pwr_next;
      pw_cnt_reg   <= pw_cnt_next;
      mode_reg     <= mode_next;
      bst_act_reg  <= bst_act_next;
      bst_rd_reg   <= bst_rd_next;
      bst_ap_reg   <= bst_ap_next;
      bst_bank_reg <= bst_bank_next;
      bst_col_reg  <= bst_col_next;
      bst_len_reg  <= bst_len_next;
      bst_left_reg <= bst_left_next;
      pv_reg       <= pv_next;
      pm_reg       <= pm_next;
      pd_reg       <= pd_next;
      bank_reg     <= bank_next;
      btim_reg     <= btim_next;
    end
  end

  // Write data queues here; the array port gives reads priority, so the
  // queue drains only on edges without a read fetch and while not frozen.
  sdp_fifo #(
    .WIDTH (FW),
    .DEPTH (FIFO_DEPTH)
  ) u_wbuf (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (wr_push),
    .in_ready  (f_ready),
    .in_data   ({wr_addr, dq_in}),
    .out_valid (f_valid),
    .out_ready (act && !rd_push),
    .out_data  (f_data)
  );

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      valid_reg <= '0;
    end else if (wipe) begin
      valid_reg <= '0;
    end else if (f_valid && act && !rd_push) begin
      valid_reg[f_data[FW-1:DATA_W]] <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (f_valid && act && !rd_push && !wipe) begin
      mem[f_data[FW-1:DATA_W]] <= f_data[DATA_W-1:0];
    end
  end

  assign dq_out          = pd_reg[0];
  assign dq_oe           = pv_reg[0] & ~pm_reg[0];
  assign in_deep_sleep   = (pwr_reg == PW_DS);
  assign in_self_refresh = (pwr_reg == PW_SR) || (pwr_reg == PW_XSR);
  assign in_power_down   = (pwr_reg == PW_PD);
  assign in_suspend      = (pwr_reg == PW_SUSP);
  assign ds_recovering   = (pwr_reg == PW_DSREC);
  assign mode_out        = mode_reg;
endmodule : sdp_core

// *** verif/sdp_core_assertions.sv ***
`timescale 1ns/10ps
module sdp_core_assertions #(
  parameter int DATA_W = 16
) (
  // Clock and reset
  input wire logic                       clk_sys,
  input wire logic                       rst,
  // Command pins
  input wire logic                       cke,
  input wire logic                       cs_n,
  input wire logic                       ras_n,
  input wire logic                       cas_n,
  input wire logic                       we_n,
  // Data and status
  input wire logic [DATA_W-1:0]          dq_out,
  input wire logic                       dq_oe,
  input wire logic                       in_deep_sleep,
  input wire logic                       in_self_refresh,
  input wire logic                       in_power_down,
  input wire logic                       in_suspend,
  input wire logic                       ds_recovering,
  input wire logic                       all_idle,
  input wire logic [sdp_pkg::ADDR_W-1:0] mode_out
);
  import sdp_pkg::*;
  logic       cke_reg;
  logic       cke_next;
  logic [3:0] cmd;
  logic       idle_fall;
  // The gate history restarts low, just as the device's does, so entry is never guessed early.
  always_comb begin
    cke_next  = cke;
    cmd       = {cs_n, ras_n, cas_n, we_n};
    idle_fall = cke_reg && !cke && all_idle && !(in_suspend || in_power_down ||
                in_self_refresh || in_deep_sleep || ds_recovering);
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cke_reg <= 1'b0;
    end else begin
      cke_reg <= cke_next;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  a_ds_entry: assert property (idle_fall && cmd == CMD_BST |=> in_deep_sleep)
    else $error("deep sleep not entered");
  a_bst_plain: assert property (cke_reg && cke && cmd == CMD_BST |=> !in_deep_sleep)
    else $error("burst terminate with gate high entered deep sleep");
  a_ds_stay: assert property (in_deep_sleep && !cke |=> in_deep_sleep)
    else $error("deep sleep left with gate low");
  a_ds_exit: assert property (in_deep_sleep && cke |=> !in_deep_sleep && ds_recovering)
    else $error("deep sleep exit missed");
  a_ds_wait: assert property ($rose(ds_recovering) |-> ds_recovering [*8])
    else $error("deep sleep recovery ended early");
  a_mode_keep: assert property (in_deep_sleep |=> $stable(mode_out))
    else $error("mode value changed in deep sleep");
  a_susp_freeze: assert property (in_suspend && !cke |=> $stable(dq_out) && $stable(dq_oe))
    else $error("output moved on a suspended edge");
  a_pd_entry: assert property (idle_fall && cmd == CMD_NOP |=> in_power_down)
    else $error("power-down not entered");
  a_pd_exit: assert property (in_power_down && cke && (cs_n || cmd == CMD_NOP)
    |=> !in_power_down && all_idle)
    else $error("power-down exit not idle on next edge");
  a_sr_entry: assert property (idle_fall && cmd == CMD_REF |=> in_self_refresh)
    else $error("self refresh not entered");
  a_sr_stay: assert property (in_self_refresh && !cke |=> in_self_refresh)
    else $error("self refresh left with gate low");
endmodule : sdp_core_assertions

// *** verif/sdp_ctrl_model.sv ***
`timescale 1ns/10ps
module sdp_ctrl_model (
  // Clock
  input  wire logic                       clk_sys,
  // Command pins
  output logic                            cke,
  output logic                            cs_n,
  output logic                            ras_n,
  output logic                            cas_n,
  output logic                            we_n,
  output logic [1:0]                      ba,
  output logic [sdp_pkg::ADDR_W-1:0]      addr,
  // Data pins
  output logic                            dqm,
  output logic [15:0]                     dq_in
);
  import sdp_pkg::*;
  initial begin
    cke = 1'b0;
    {cs_n, ras_n, cas_n, we_n} = CMD_NOP;
    ba = 2'h0;
    addr = 13'h0000;
    dqm = 1'b0;
    dq_in = 16'h0000;
  end
  // Outside write data the bus toggles between the last word written and its complement.
  task automatic step(input logic [3:0] c = CMD_NOP, input logic [1:0] b = 2'h0,
                      input logic [12:0] a = 13'h0000, input logic [15:0] d = 16'h0000,
                      input logic g = 1'b1, input logic wd = 1'b0, input logic m = 1'b0);
    @(posedge clk_sys);
    cke <= g;
    dqm <= m;
    {cs_n, ras_n, cas_n, we_n} <= c;
    ba <= b;
    addr <= a;
    dq_in <= (c == CMD_WR || wd) ? d : ~dq_in;
  endtask : step
  task automatic nop(input int n);
    repeat (n) step();
  endtask : nop
  task automatic wdat(input logic [15:0] d);
    step(CMD_NOP, 2'h0, 13'h0000, d, 1'b1, 1'b1);
  endtask : wdat
  task automatic hold_low(input int n);
    repeat (n) step(CMD_NOP, 2'h0, 13'h0000, 16'h0000, 1'b0);
  endtask : hold_low
  task automatic ds_enter();
    step(CMD_BST, 2'h0, 13'h0000, 16'h0000, 1'b0);
  endtask : ds_enter
  // The array comes back unpowered, so the full wake-up sequence is always walked.
  task automatic ds_recover(input int wait_cyc);
    step();
    nop(wait_cyc);
    step(CMD_PRE, 2'h0, 13'h0400);
    nop(RP_CYC);
    step(CMD_REF);
    nop(2);
    step(CMD_REF);
    nop(2);
  endtask : ds_recover
  task automatic sr_recover();
    step();
    nop(XSR_CYC + 2);
  endtask : sr_recover
endmodule : sdp_ctrl_model

// *** verif/sdp_core_test.sv ***
`timescale 1ns/10ps
module sdp_core_test;
  import sdp_pkg::*;
  localparam int          DSW = 20;
  localparam logic [15:0] PSN = 16'hffff;
  logic        clk_sys;
  logic        rst;
  logic        cke, cs_n, ras_n, cas_n, we_n, dqm, dq_oe, wbuf_ready;
  logic        in_deep_sleep, in_self_refresh, in_power_down, in_suspend, ds_recovering;
  logic        all_idle;
  logic [1:0]  ba;
  logic [12:0] addr;
  logic [12:0] mode_out;
  logic [15:0] dq_in;
  logic [15:0] dq_out;
  int          fails;
  int          checked;

  sdp_core #(.DS_WAIT(DSW)) DUT (
    .clk_sys(clk_sys), .rst(rst), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .ba(ba), .addr(addr), .dqm(dqm), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe(dq_oe), .in_deep_sleep(in_deep_sleep), .in_self_refresh(in_self_refresh),
    .in_power_down(in_power_down), .in_suspend(in_suspend), .ds_recovering(ds_recovering),
    .all_idle(all_idle), .wbuf_ready(wbuf_ready), .mode_out(mode_out));
  sdp_ctrl_model u_ctrl (
    .clk_sys(clk_sys), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .ba(ba), .addr(addr), .dqm(dqm), .dq_in(dq_in));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic results();
    if (fails == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results
  task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word
  task automatic chk_flag(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_flag
  // Read of two words at read latency two, each sampled while it stands.
  task automatic rd2(input logic [1:0] b, input logic [12:0] a, input logic [15:0] e0,
                     input logic [15:0] e1);
    u_ctrl.step(CMD_RD, b, a);
    u_ctrl.nop(2);
    #1;
    chk_flag("dq_oe", 1'b1, dq_oe);
    chk_word("first word", e0, dq_out);
    u_ctrl.nop(1);
    #1;
    chk_word("second word", e1, dq_out);
  endtask : rd2
  task automatic act2();
    u_ctrl.step(CMD_ACT, 2'h0);
    u_ctrl.step(CMD_ACT, 2'h1);
    u_ctrl.nop(1);
  endtask : act2

  initial begin
    fork
      begin
        repeat (3000) @(posedge clk_sys);
        fails++;
        results();
      end
    join_none
  end

  initial begin
    rst = 1'b1;
    fails = 0;
    checked = 0;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    chk_flag("all_idle", 1'b1, all_idle);
    chk_flag("wbuf_ready", 1'b1, wbuf_ready);
    chk_word("mode_out", 16'h0020, {3'h0, mode_out});
    u_ctrl.nop(3);
    u_ctrl.step(CMD_LMR, 2'h0, 13'h0021);
    act2();
    u_ctrl.step(CMD_WR, 2'h0, 13'h0000, 16'h1111);
    u_ctrl.wdat(16'h2222);
    u_ctrl.nop(8);
    rd2(2'h0, 13'h0000, 16'h1111, 16'h2222);
    // Gate drops one edge after the read, and a read is offered on a frozen edge.
    u_ctrl.step(CMD_RD, 2'h0, 13'h0000);
    u_ctrl.step(CMD_NOP, 2'h0, 13'h0000, 16'h0000, 1'b0);
    u_ctrl.step(CMD_RD, 2'h0, 13'h0002, 16'h0000, 1'b0);
    u_ctrl.step();
    #1;
    chk_flag("in_suspend", 1'b1, in_suspend);
    chk_word("suspended word", 16'h1111, dq_out);
    u_ctrl.step();
    #1;
    chk_word("held word", 16'h1111, dq_out);
    u_ctrl.step();
    #1;
    chk_word("resumed word", 16'h2222, dq_out);
    u_ctrl.nop(2);
    #1;
    chk_flag("dq_oe after burst", 1'b0, dq_oe);
    u_ctrl.step(CMD_RD, 2'h0, 13'h0400);
    rd2(2'h1, 13'h0400, PSN, PSN);
    u_ctrl.nop(14);
    #1;
    chk_flag("all_idle", 1'b1, all_idle);
    act2();
    u_ctrl.step(CMD_WR, 2'h0, 13'h0408, 16'h7777);
    u_ctrl.step(CMD_WR, 2'h1, 13'h0408, 16'h8888);
    u_ctrl.wdat(16'h9999);
    u_ctrl.nop(16);
    #1;
    chk_flag("all_idle", 1'b1, all_idle);
    act2();
    rd2(2'h0, 13'h0008, 16'h7777, PSN);
    u_ctrl.step(CMD_PRE, 2'h0, 13'h0400);
    u_ctrl.nop(RP_CYC + 1);
    // Bank two recovers from its cut write before its precharge may even start.
    u_ctrl.step(CMD_ACT, 2'h2);
    u_ctrl.step(CMD_ACT, 2'h3);
    u_ctrl.step(CMD_WR, 2'h2, 13'h0410, 16'h3333);
    u_ctrl.step(CMD_RD, 2'h3, 13'h04f0);
    u_ctrl.nop(WR_CYC + RP_CYC);
    #1;
    chk_flag("all_idle in recovery", 1'b0, all_idle);
    u_ctrl.nop(1);
    #1;
    chk_flag("all_idle", 1'b1, all_idle);
    u_ctrl.step(CMD_ACT, 2'h2);
    u_ctrl.step(CMD_ACT, 2'h3, 13'h0000, 16'h0000, 1'b1, 1'b0, 1'b1);
    u_ctrl.step(CMD_RD, 2'h2, 13'h0410);
    u_ctrl.step(CMD_WR, 2'h3, 13'h0010, 16'h4444);
    u_ctrl.step(CMD_NOP, 2'h3, 13'h0000, 16'h5555, 1'b1, 1'b1, 1'b1);
    #1;
    chk_flag("dq_oe cut by write", 1'b0, dq_oe);
    u_ctrl.nop(WR_CYC + RP_CYC + 2);
    u_ctrl.step(CMD_ACT, 2'h2);
    u_ctrl.step(CMD_ACT, 2'h3);
    u_ctrl.nop(1);
    rd2(2'h3, 13'h0010, 16'h4444, PSN);
    rd2(2'h2, 13'h0010, 16'h3333, PSN);
    u_ctrl.step(CMD_LMR, 2'h0, 13'h0221);
    act2();
    u_ctrl.step(CMD_WR, 2'h0, 13'h0004, 16'h5555);
    u_ctrl.wdat(16'h6666);
    u_ctrl.nop(8);
    rd2(2'h0, 13'h0004, 16'h5555, PSN);
    u_ctrl.step(CMD_PRE, 2'h0, 13'h0400);
    u_ctrl.nop(RP_CYC + 1);
    u_ctrl.hold_low(2);
    #1;
    chk_flag("in_power_down", 1'b1, in_power_down);
    u_ctrl.step();
    #1;
    chk_flag("all_idle", 1'b1, all_idle);
    u_ctrl.nop(1);
    u_ctrl.step(CMD_REF, 2'h0, 13'h0000, 16'h0000, 1'b0);
    u_ctrl.hold_low(2);
    #1;
    chk_flag("in_self_refresh", 1'b1, in_self_refresh);
    u_ctrl.sr_recover();
    #1;
    chk_flag("in_self_refresh", 1'b0, in_self_refresh);
    u_ctrl.step(CMD_BST);
    u_ctrl.nop(1);
    #1;
    chk_flag("in_deep_sleep", 1'b0, in_deep_sleep);
    u_ctrl.ds_enter();
    u_ctrl.hold_low(3);
    #1;
    chk_flag("in_deep_sleep", 1'b1, in_deep_sleep);
    u_ctrl.ds_recover(DSW + 2);
    #1;
    chk_flag("ds_recovering", 1'b0, ds_recovering);
    chk_word("mode_out", 16'h0221, {3'h0, mode_out});
    act2();
    rd2(2'h0, 13'h0000, PSN, PSN);
    results();
  end
endmodule : sdp_core_test

bind sdp_core sdp_core_assertions #(.DATA_W(DATA_W)) u_chk (
  .clk_sys(clk_sys), .rst(rst), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
  .we_n(we_n), .dq_out(dq_out), .dq_oe(dq_oe), .in_deep_sleep(in_deep_sleep),
  .in_self_refresh(in_self_refresh), .in_power_down(in_power_down), .in_suspend(in_suspend),
  .ds_recovering(ds_recovering), .all_idle(all_idle), .mode_out(mode_out));
